/* rtl/isnf_pkg.sv */
/*
  Shared constants and types of the input signal noise filter: bus map,
  setting word layout, command code, timing base and input group table.
  Assumes a single 100 MHz system clock and an AHB-Lite register bus.
*/
`default_nettype none

package isnf_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BASE_DELAY_NS = 500;
  // Shortest stage delay in cycles; code n doubles it n times
  localparam int unsigned BASE_CYC =
    (BASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W  = 21;
  localparam int CODE_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 21'h0_0001;

  // ************************************************************
  // Setting word, command word
  // ************************************************************
  localparam int SET_W = 16;
  localparam logic [7:0] CMD_FILTER_MODE = 8'h25;
  localparam int EMG_ENABLE_BIT = 0;

  typedef struct packed {
    logic [CODE_W-1:0] tcB;
    logic [CODE_W-1:0] tcA;
    logic [7:0]        enable;
  } isnf_setting_t;

  localparam isnf_setting_t SET_RESET = 16'h0000;

  typedef struct packed {
    logic [5:0] unused;
    logic       axisY;
    logic       axisX;
    logic [7:0] code;
  } isnf_cmd_t;

  // ************************************************************
  // Per-axis external inputs, raw or filtered
  // ************************************************************
  typedef struct packed {
    logic       encoderPhaseB;
    logic       encoderPhaseA;
    logic       stopIn2;
    logic [5:0] generalPinsHigh;
    logic [7:0] generalPinsLow;
    logic       servoAlarmIn;
    logic       inPositionIn;
    logic       stopIn1;
    logic       stopIn0;
    logic       minusLimitIn;
    logic       plusLimitIn;
  } isnf_axis_in_t;

  localparam int AXIS_IN_W = 23;
  localparam int NUM_AXES  = 2;
  localparam int PIN_W     = 1 + NUM_AXES * AXIS_IN_W;
  localparam logic [2:0] FIRST_GROUP_B = 3'h6;

  // Enable bit that covers a given bit of isnf_axis_in_t
  function automatic logic [2:0] groupOf(input int unsigned bitIdx);
    logic [2:0] g;
    if (bitIdx < 2) g = 3'h1;
    else if (bitIdx < 4) g = 3'h2;
    else if (bitIdx < 6) g = 3'h3;
    else if (bitIdx < 14) g = 3'h4;
    else if (bitIdx < 20) g = 3'h5;
    else if (bitIdx < 21) g = 3'h6;
    else g = 3'h7;
    return g;
  endfunction

  // ************************************************************
  // AHB-Lite
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_DATA    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMD     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_XSET    = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_YSET    = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_XSTAT   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_YSTAT   = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_ESTAT   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_LASTCMD = 8'h1C;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic              apValid;
    logic              apWrite;
    logic [ADDR_W-1:0] apAddr;
    isnf_setting_t     dataReg;
    isnf_setting_t     xSet;
    isnf_setting_t     ySet;
    isnf_cmd_t         lastCmd;
    logic [31:0]       rdata;
    logic              readyOut;
    logic              resp;
  } isnf_top_state_t;

endpackage

`default_nettype wire

/* rtl/isnf_sync2.sv */
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes the pins are unrelated single-bit levels; no bus coherency.
*/
`timescale 1ns/100ps
`default_nettype none

module isnf_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] pinSync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } isnf_sync_state_t;

  isnf_sync_state_t st;
  isnf_sync_state_t next_st;

  always_comb begin
    next_st.meta = pinIn;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinSync = st.sync;

endmodule

`default_nettype wire

/* rtl/isnf_filter_cell.sv */
/*
  One integrating noise filter for a single synchronised input.
  Assumes rawIn is already on the clk domain; enable and tcCode are
  register outputs on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module isnf_filter_cell #(
  parameter int unsigned BASE_CYCLES = isnf_pkg::BASE_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        rawIn,
  input  wire logic                        enable,
  input  wire logic [isnf_pkg::CODE_W-1:0] tcCode,
  output var  logic                        filtOut
);

  typedef struct packed {
    logic [isnf_pkg::CNT_W-1:0] count;
    logic                       level;
  } isnf_cell_state_t;

  isnf_cell_state_t           st;
  isnf_cell_state_t           next_st;
  logic [isnf_pkg::CNT_W-1:0] limit;

  // Full scale doubles per code step
  assign limit = isnf_pkg::CNT_W'(BASE_CYCLES) << tcCode;

  // ************************************************************
  // Up/down integrator
  // ************************************************************
  always_comb begin
    next_st = st;
    if (!enable) begin
      // Tracks the input so enabling later starts without a glitch
      next_st.count = rawIn ? limit : '0;
      next_st.level = rawIn;
    end else if (rawIn) begin
      // Short pulses only nudge the count: noise is rejected
      if (st.count >= limit - isnf_pkg::CNT_ONE) begin
        next_st.count = limit;
        next_st.level = 1'b1;
      end else begin
        next_st.count = st.count + isnf_pkg::CNT_ONE;
      end
    end else begin
      if (st.count <= isnf_pkg::CNT_ONE) begin
        next_st.count = '0;
        next_st.level = 1'b0;
      end else if (st.count > limit) begin
        // Code lowered mid-count: clamp to one step below the new full scale
        next_st.count = limit - isnf_pkg::CNT_ONE;
      end else begin
        next_st.count = st.count - isnf_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtOut = st.level;

  // ************************************************************
  // Checks
  // ************************************************************
  a_bypass_through: assert property (
    @(posedge clk) disable iff (sys_rst)
    !enable |=> filtOut == $past(rawIn))
    else $error("bypassed cell did not follow its input");

  a_rise_at_limit: assert property (
    @(posedge clk) disable iff (sys_rst)
    enable && !st.level && rawIn && st.count == limit - isnf_pkg::CNT_ONE
    |=> filtOut)
    else $error("output did not rise at full scale");

  a_hold_midway: assert property (
    @(posedge clk) disable iff (sys_rst)
    enable && st.level && !rawIn && st.count > isnf_pkg::CNT_ONE
    && limit > isnf_pkg::CNT_ONE |=> filtOut)
    else $error("output fell before the integrator emptied");

endmodule

`default_nettype wire

/* rtl/isnf_input_filter.sv */
/*
  Input signal noise filter bank for two axes with AHB-Lite registers.
  Assumes one AHB-Lite master with this block as its only slave, and
  external pins asynchronous to clk.
*/
// Behaviour
// - Every axis input has its own integrating filter; Y copies X.
// - Constants A and B; the input type fixes which one applies.
// - Enables and both codes load together on command 25h.
// - Enable bit 1 filters its group, 0 passes the raw signal.
// - Bits 0-5 use constant A, bits 6 and 7 use constant B.
// - Emergency stop filter enable comes only from the X setting.
// - Bits 11-8 select constant A, bits 15-12 constant B.
// - Code n gives 500 ns times two to the n delay.
// - Each stage rejects noise up to seven eighths of its delay.
// - Reset clears all filter enables; inputs pass straight through.
`timescale 1ns/100ps
`default_nettype none

module isnf_input_filter #(
  parameter int unsigned BASE_CYCLES = isnf_pkg::BASE_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output var  logic                    hreadyout,
  output var  logic                    hresp,
  output var  logic [31:0]             hrdata,
  input  wire logic                    emergencyStopIn,
  input  wire isnf_pkg::isnf_axis_in_t xIn,
  input  wire isnf_pkg::isnf_axis_in_t yIn,
  output var  logic                    emergencyStopOut,
  output var  isnf_pkg::isnf_axis_in_t xOut,
  output var  isnf_pkg::isnf_axis_in_t yOut
);

  isnf_pkg::isnf_top_state_t st;
  isnf_pkg::isnf_top_state_t next_st;

  logic [isnf_pkg::PIN_W-1:0]     pinSync;
  logic [isnf_pkg::AXIS_IN_W-1:0] xSync;
  logic [isnf_pkg::AXIS_IN_W-1:0] ySync;
  logic                           emgSync;
  logic [isnf_pkg::AXIS_IN_W-1:0] xFilt;
  logic [isnf_pkg::AXIS_IN_W-1:0] yFilt;
  logic                           emgFilt;
  isnf_pkg::isnf_cmd_t            cmdWord;
  logic                           addrPhase;
  logic                           cmdWrite;
  logic                           cmdLoadX;
  logic                           cmdLoadY;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  isnf_sync2 #(
    .W (isnf_pkg::PIN_W)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   ({emergencyStopIn, yIn, xIn}),
    .pinSync (pinSync)
  );

  assign xSync   = pinSync[isnf_pkg::AXIS_IN_W-1:0];
  assign ySync   = pinSync[2*isnf_pkg::AXIS_IN_W-1:isnf_pkg::AXIS_IN_W];
  assign emgSync = pinSync[2*isnf_pkg::AXIS_IN_W];

  // ************************************************************
  // Filter cells
  // ************************************************************
  // Axis 0 is X, axis 1 is Y; the same cell layout serves both
  for (genvar a = 0; a < isnf_pkg::NUM_AXES; a++) begin : g_axis
    isnf_pkg::isnf_setting_t        axisSet;
    logic [isnf_pkg::AXIS_IN_W-1:0] axisRaw;
    logic [isnf_pkg::AXIS_IN_W-1:0] axisFilt;

    assign axisSet = (a == 0) ? st.xSet : st.ySet;
    assign axisRaw = (a == 0) ? xSync : ySync;

    for (genvar b = 0; b < isnf_pkg::AXIS_IN_W; b++) begin : g_bit
      localparam logic [2:0] GRP = isnf_pkg::groupOf(b);
      // Constant choice is wired by input type, not by software
      localparam logic USE_B = (GRP >= isnf_pkg::FIRST_GROUP_B);

      isnf_filter_cell #(
        .BASE_CYCLES (BASE_CYCLES)
      ) u_cell (
        .clk     (clk),
        .sys_rst (sys_rst),
        .rawIn   (axisRaw[b]),
        .enable  (axisSet.enable[GRP]),
        .tcCode  (USE_B ? axisSet.tcB : axisSet.tcA),
        .filtOut (axisFilt[b])
      );
    end

    if (a == 0) begin : g_x
      assign xFilt = axisFilt;
    end else begin : g_y
      assign yFilt = axisFilt;
    end
  end

  // Shared pin: its enable and constant come from the X setting only
  isnf_filter_cell #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_emg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rawIn   (emgSync),
    .enable  (st.xSet.enable[isnf_pkg::EMG_ENABLE_BIT]),
    .tcCode  (st.xSet.tcA),
    .filtOut (emgFilt)
  );

  assign xOut             = isnf_pkg::isnf_axis_in_t'(xFilt);
  assign yOut             = isnf_pkg::isnf_axis_in_t'(yFilt);
  assign emergencyStopOut = emgFilt;

  // ************************************************************
  // Bus decode and command
  // ************************************************************
  assign cmdWord   = isnf_pkg::isnf_cmd_t'(hwdata[isnf_pkg::SET_W-1:0]);
  assign addrPhase = hsel && hready
                     && (htrans == isnf_pkg::HTRANS_NONSEQ
                         || htrans == isnf_pkg::HTRANS_SEQ);
  assign cmdWrite  = st.apValid && st.apWrite
                     && st.apAddr == isnf_pkg::ADDR_CMD;
  // Any other code is taken but changes no setting
  assign cmdLoadX  = cmdWrite && cmdWord.code == isnf_pkg::CMD_FILTER_MODE
                     && cmdWord.axisX;
  assign cmdLoadY  = cmdWrite && cmdWord.code == isnf_pkg::CMD_FILTER_MODE
                     && cmdWord.axisY;

  always_comb begin
    next_st = st;
    next_st.readyOut = 1'b1;
    next_st.resp     = isnf_pkg::HRESP_OKAY;

    // Data phase of a write
    if (st.apValid && st.apWrite && st.apAddr == isnf_pkg::ADDR_DATA) begin
      next_st.dataReg =
        isnf_pkg::isnf_setting_t'(hwdata[isnf_pkg::SET_W-1:0]);
    end
    if (cmdWrite) begin
      next_st.lastCmd = cmdWord;
    end
    // All three fields of a setting move in one step
    if (cmdLoadX) begin
      next_st.xSet = st.dataReg;
    end
    if (cmdLoadY) begin
      next_st.ySet = st.dataReg;
    end

    // Address phase; reads see writes of the preceding data phase
    next_st.apValid = addrPhase;
    next_st.apWrite = hwrite;
    next_st.apAddr  = haddr[isnf_pkg::ADDR_W-1:0];
    if (addrPhase && !hwrite) begin
      case (haddr[isnf_pkg::ADDR_W-1:0])
        isnf_pkg::ADDR_DATA:    next_st.rdata = 32'(next_st.dataReg);
        isnf_pkg::ADDR_XSET:    next_st.rdata = 32'(next_st.xSet);
        isnf_pkg::ADDR_YSET:    next_st.rdata = 32'(next_st.ySet);
        isnf_pkg::ADDR_XSTAT:   next_st.rdata = 32'(xFilt);
        isnf_pkg::ADDR_YSTAT:   next_st.rdata = 32'(yFilt);
        isnf_pkg::ADDR_ESTAT:   next_st.rdata = 32'(emgFilt);
        isnf_pkg::ADDR_LASTCMD: next_st.rdata = 32'(next_st.lastCmd);
        default:                next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st          <= '0;
      st.readyOut <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = st.readyOut;
  assign hresp     = st.resp;
  assign hrdata    = st.rdata;

  // ************************************************************
  // Checks
  // ************************************************************
  a_reset_clears_enables: assert property (
    @(posedge clk)
    sys_rst |=> st.xSet.enable == 8'h00 && st.ySet.enable == 8'h00)
    else $error("filter enables not cleared by reset");

  a_cmd_loads_x: assert property (
    @(posedge clk) disable iff (sys_rst)
    cmdLoadX |=> st.xSet == $past(st.dataReg))
    else $error("X setting not loaded by filter command");

  a_cmd_spares_y: assert property (
    @(posedge clk) disable iff (sys_rst)
    !cmdLoadY |=> $stable(st.ySet))
    else $error("Y setting changed without filter command");

  a_cmd_loads_y: assert property (
    @(posedge clk) disable iff (sys_rst)
    cmdLoadY |=> st.ySet == $past(st.dataReg))
    else $error("Y setting not loaded by filter command");

  a_cmd_spares_x: assert property (
    @(posedge clk) disable iff (sys_rst)
    !cmdLoadX |=> $stable(st.xSet))
    else $error("X setting changed without filter command");

  a_other_code_inert: assert property (
    @(posedge clk) disable iff (sys_rst)
    cmdWrite && cmdWord.code != isnf_pkg::CMD_FILTER_MODE
    |=> $stable(st.xSet) && $stable(st.ySet))
    else $error("setting changed by another command code");

  a_data_word_taken: assert property (
    @(posedge clk) disable iff (sys_rst)
    st.apValid && st.apWrite && st.apAddr == isnf_pkg::ADDR_DATA
    |=> st.dataReg == $past(hwdata[isnf_pkg::SET_W-1:0]))
    else $error("data register missed a write");

  a_lastcmd_taken: assert property (
    @(posedge clk) disable iff (sys_rst)
    cmdWrite |=> st.lastCmd == $past(cmdWord))
    else $error("command word not recorded");

  a_emg_x_only: assert property (
    @(posedge clk) disable iff (sys_rst)
    !st.xSet.enable[isnf_pkg::EMG_ENABLE_BIT]
    |=> emergencyStopOut == $past(emgSync))
    else $error("emergency stop filtered while X enable is off");

  a_bus_okay: assert property (
    @(posedge clk) disable iff (sys_rst)
    hreadyout && hresp == isnf_pkg::HRESP_OKAY)
    else $error("bus slave stalled or answered with an error");

  // ************************************************************
  // Checks: bus side and reset of filtered outputs
  // ************************************************************
  a_rdata_holds: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(addrPhase && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_ready_after_reset: assert property (
    @(posedge clk)
    sys_rst |=> hreadyout && hresp == isnf_pkg::HRESP_OKAY)
    else $error("bus slave not ready after reset");

  a_reset_clears_outputs: assert property (
    @(posedge clk)
    sys_rst
    |=> xOut == '0 && yOut == '0 && !emergencyStopOut)
    else $error("filtered outputs not cleared by reset");

  a_data_readback: assert property (
    @(posedge clk) disable iff (sys_rst)
    addrPhase && !hwrite && !(st.apValid && st.apWrite)
    && haddr[isnf_pkg::ADDR_W-1:0] == isnf_pkg::ADDR_DATA
    |=> hrdata == 32'($past(st.dataReg)))
    else $error("data register read back wrong");

  a_xset_readback: assert property (
    @(posedge clk) disable iff (sys_rst)
    addrPhase && !hwrite && !cmdLoadX
    && haddr[isnf_pkg::ADDR_W-1:0] == isnf_pkg::ADDR_XSET
    |=> hrdata == 32'($past(st.xSet)))
    else $error("X setting read back wrong");

  a_yset_readback: assert property (
    @(posedge clk) disable iff (sys_rst)
    addrPhase && !hwrite && !cmdLoadY
    && haddr[isnf_pkg::ADDR_W-1:0] == isnf_pkg::ADDR_YSET
    |=> hrdata == 32'($past(st.ySet)))
    else $error("Y setting read back wrong");

  a_ystat_readback: assert property (
    @(posedge clk) disable iff (sys_rst)
    addrPhase && !hwrite
    && haddr[isnf_pkg::ADDR_W-1:0] == isnf_pkg::ADDR_YSTAT
    |=> hrdata == 32'($past(yFilt)))
    else $error("Y filtered inputs read back wrong");

  a_estat_readback: assert property (
    @(posedge clk) disable iff (sys_rst)
    addrPhase && !hwrite
    && haddr[isnf_pkg::ADDR_W-1:0] == isnf_pkg::ADDR_ESTAT
    |=> hrdata == 32'($past(emgFilt)))
    else $error("emergency filtered bit read back wrong");

endmodule

`default_nettype wire

/* test/isnf_pin_source.sv */
/*
  Far side of the filter bank: switches, sensors and encoder phases.
  Assumes the bench sets levels and noise width right after clk edges.
*/
`timescale 1ns/100ps
`default_nettype none

module isnf_pin_source (
  input  wire logic                    clk,
  input  wire logic                    levE,
  input  wire isnf_pkg::isnf_axis_in_t levX,
  input  wire isnf_pkg::isnf_axis_in_t levY,
  input  wire logic [7:0]              noiseW,
  output var  logic                    emergencyStopIn,
  output var  isnf_pkg::isnf_axis_in_t xIn,
  output var  isnf_pkg::isnf_axis_in_t yIn
);
  // ************************************************************
  // Noise bursts
  // ************************************************************
  logic [9:0] phase;
  logic       burst;

  // One burst of noiseW cycles in every 4*noiseW: quarter duty
  assign burst = (noiseW != 8'h00) && (phase < {2'h0, noiseW});

  always_ff @(posedge clk) begin
    if (noiseW == 8'h00 || phase + 10'h001 >= {noiseW, 2'h0}) begin
      phase <= 10'h000;
    end else begin
      phase <= phase + 10'h001;
    end
    emergencyStopIn <= levE ^ burst;
    xIn             <= levX ^ {23{burst}};
    yIn             <= levY;
  end
endmodule

`default_nettype wire

/* test/testbench.sv */
/*
  Self-checking bench of the filter bank: AHB-Lite master, setting
  model, delay, mapping and noise scenarios.
  Assumes zero wait states on the bus and BASE_CYCLES set small.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
  end end

module testbench;
  localparam int unsigned BASE = 2;
  localparam int REP [8] = '{0, 0, 2, 4, 6, 14, 20, 22};
  logic                    clk;
  logic                    sys_rst;
  logic                    hsel;
  logic                    hwrite;
  logic                    hreadyout;
  logic                    hresp;
  logic                    levE;
  logic                    emergencyStopIn;
  logic                    emergencyStopOut;
  logic [31:0]             haddr;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic [31:0]             rd;
  logic [31:0]             rnd;
  logic [1:0]              htrans;
  logic [2:0]              hsize;
  logic [7:0]              noiseW;
  isnf_pkg::isnf_axis_in_t levX;
  isnf_pkg::isnf_axis_in_t levY;
  isnf_pkg::isnf_axis_in_t xIn;
  isnf_pkg::isnf_axis_in_t yIn;
  isnf_pkg::isnf_axis_in_t xOut;
  isnf_pkg::isnf_axis_in_t yOut;
  int                      err_count;
  int                      check_count;
  int                      cyc;
  int                      bad;
  int                      xSetM;
  int                      ySetM;

  isnf_input_filter #(.BASE_CYCLES(BASE)) i_isnf_input_filter (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .emergencyStopIn(emergencyStopIn), .xIn(xIn),
    .yIn(yIn), .emergencyStopOut(emergencyStopOut), .xOut(xOut),
    .yOut(yOut));

  isnf_pin_source i_isnf_pin_source (
    .clk(clk), .levE(levE), .levX(levX), .levY(levY), .noiseW(noiseW),
    .emergencyStopIn(emergencyStopIn), .xIn(xIn), .yIn(yIn));

  // ************************************************************
  // Clock, timeout, verdict
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    $display("mismatches %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ************************************************************
  // Bus master and model
  // ************************************************************
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= isnf_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, isnf_pkg::HRESP_OKAY)
  endtask

  task automatic rd32(input logic [7:0] a);
    ahb(a, 1'b0, 32'h0000_0000);
  endtask

  // Data word first, then the command naming one axis
  task automatic setAxis(input int ax, input logic [15:0] v);
    ahb(isnf_pkg::ADDR_DATA, 1'b1, {16'h0000, v});
    ahb(isnf_pkg::ADDR_CMD, 1'b1,
        (ax == 1) ? 32'h0000_0225 : 32'h0000_0125);
    if (ax == 1) ySetM = v;
    else xSetM = v;
  endtask

  function automatic int lenOf(input int c);
    return BASE << c;
  endfunction

  function automatic logic outBit(input int ax, input int b);
    return ax == 2 ? emergencyStopOut : ax == 1 ? yOut[b] : xOut[b];
  endfunction

  // Raise then lower one pin; cycles to the output must lie in lo..hi
  task automatic measure(input int ax, input int b, input int lo,
                         input int hi);
    int n;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      if (ax == 2) levE <= (k == 0);
      else if (ax == 1) levY[b] <= (k == 0);
      else levX[b] <= (k == 0);
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (outBit(ax, b) !== (k == 0) && n < 5000);
      `CHK(n >= lo && n <= hi, 1'b1)
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    levE = 1'b0;
    levX = '0;
    levY = '0;
    noiseW = 8'h00;
    {err_count, check_count, cyc, xSetM, ySetM} = '0;
    rnd = $urandom(70110);
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    ahb(8'h20, 1'b1, 32'h0000_FFFF);
    ahb(isnf_pkg::ADDR_XSET, 1'b1, 32'h0000_FFFF);
    rd32(isnf_pkg::ADDR_XSET);
    `CHK(rd, 32'h0000_0000)
    rd32(isnf_pkg::ADDR_YSET);
    `CHK(rd, 32'h0000_0000)
    repeat (8) begin
      rnd = $urandom;
      levX <= rnd[22:0];
      levE <= rnd[31];
      rnd = $urandom;
      levY <= rnd[22:0];
      repeat (5) @(posedge clk);
      #1;
      `CHK(xOut, levX)
      `CHK(yOut, levY)
      `CHK(emergencyStopOut, levE)
      @(posedge clk);
      rd32(isnf_pkg::ADDR_XSTAT);
      `CHK(rd[22:0], levX)
      rd32(isnf_pkg::ADDR_YSTAT);
      `CHK(rd[22:0], levY)
      rd32(isnf_pkg::ADDR_ESTAT);
      `CHK(rd, 32'(levE))
    end
    levX <= '0;
    levY <= '0;
    levE <= 1'b0;
    repeat (6) @(posedge clk);
    rnd = $urandom;
    setAxis(0, rnd[15:0]);
    rd32(isnf_pkg::ADDR_XSET);
    `CHK(rd, xSetM)
    rd32(isnf_pkg::ADDR_YSET);
    `CHK(rd, ySetM)
    ahb(isnf_pkg::ADDR_DATA, 1'b1, 32'h0000_FFFF);
    ahb(isnf_pkg::ADDR_CMD, 1'b1, 32'h0000_0324);
    rd32(isnf_pkg::ADDR_LASTCMD);
    `CHK(rd, 32'h0000_0324)
    rd32(isnf_pkg::ADDR_XSET);
    `CHK(rd, xSetM)
    for (int ax = 0; ax < 2; ax++) begin
      for (int g = 1; g < 8; g++) begin
        setAxis(ax, {4'h1, 4'h2, 8'h01 << g});
        measure(ax, REP[g], lenOf(g >= 6 ? 1 : 2) + 2,
                lenOf(g >= 6 ? 1 : 2) + 6);
        measure(ax, REP[g % 7 + 1], 4, 4);
      end
    end
    for (int c = 0; c < 4; c++) begin
      setAxis(0, {4'(3 - c), 4'(c), 8'h82});
      measure(0, 0, lenOf(c) + 2, lenOf(c) + 6);
      measure(0, 21, lenOf(3 - c) + 2, lenOf(3 - c) + 6);
    end
    setAxis(0, 16'h0A02);
    measure(0, 1, lenOf(10) + 2, lenOf(10) + 6);
    setAxis(0, 16'h0000);
    setAxis(1, 16'h0301);
    measure(2, 0, 4, 4);
    setAxis(0, 16'h0301);
    measure(2, 0, lenOf(3) + 2, lenOf(3) + 6);
    setAxis(0, 16'h33FF);
    for (int k = 0; k < 2; k++) begin
      levX <= k ? '1 : '0;
      levE <= k[0];
      repeat (40) @(posedge clk);
      noiseW <= 8'(lenOf(3) * 7 / 8);
      bad = 0;
      repeat (400) begin
        @(posedge clk);
        #1;
        if (xOut !== levX || emergencyStopOut !== levE) bad++;
      end
      `CHK(bad, 0)
      @(posedge clk);
      noiseW <= 8'h00;
    end
    end_sim();
  end
endmodule

`default_nettype wire
